// file: rtl/csd_top.sv
// Core sideband control drive: drives the processor core's sideband inputs.
// Assumes the core samples these levels on mclk; the register port is on the same clock.
//
// Overview of operation
// - Coprocessor absent goes low only when the attached coprocessor can serve the request.
// - Coprocessor wait is high until the coprocessor is ready, then low.
// - Data bus drive enable must be high for write data to appear.
// - Debug feature enable is static; high lets breakpoint logic work.
// - Interrupt sync select high when both irq lines are synchronous, else low.
// - Write drive enable low lets core drive data during writes.
// - Test port reset is held low for normal core operation.
// - External scan return is tied low when no external chain is attached.
// - Test float enable stays high in normal operation; low floats core outputs.
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
module csd_top (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic coproc_instr_strobe_n,
    input wire logic coproc_attached,
    input wire logic coproc_capable,
    input wire logic ext_chain_attached,
    input wire logic ext_scan_data,
    input wire logic core_running,
    output logic coproc_absent,
    output logic coproc_wait,
    output logic data_bus_drive_en,
    output logic write_drive_en_n,
    output logic debug_feature_en,
    output logic debug_entry_request,
    output logic ext_watch_cond0,
    output logic ext_watch_cond1,
    output logic irq_sync_select,
    output logic test_float_en,
    output logic test_port_reset_n,
    output logic test_clock,
    output logic test_data_in,
    output logic test_mode_select,
    output logic ext_scan_return
);
    // ------------------------------------------------------------
    // Pin inputs
    // ------------------------------------------------------------
    logic [4:0] pins_sync;
    logic strobe_n_s;
    logic cp_attached_s;
    logic cp_capable_s;
    logic chain_s;
    logic scan_s;

    // Scan data arrives on the external chain's own timing, so it is synchronised like the other pins
    csd_sync #(.WIDTH(5), .INIT(5'h10)) u_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .pin_in({coproc_instr_strobe_n, coproc_attached, coproc_capable, ext_chain_attached, ext_scan_data}),
        .sync_out(pins_sync)
    );
    assign strobe_n_s = pins_sync[4];
    assign cp_attached_s = pins_sync[3];
    assign cp_capable_s = pins_sync[2];
    assign chain_s = pins_sync[1];
    assign scan_s = pins_sync[0];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    csd_pkg::csd_ctrl_t ctrl_reg;
    csd_pkg::csd_ctrl_t ctrl_next;
    csd_pkg::csd_test_t test_reg;
    csd_pkg::csd_test_t test_next;
    logic [31:0] rdata_next;
    logic sel_ctrl;
    logic sel_test;
    logic sel_stat;
    logic static_lock;

    assign sel_ctrl = reg_addr == csd_pkg::CSD_CTRL_OFS;
    assign sel_test = reg_addr == csd_pkg::CSD_TEST_OFS;
    assign sel_stat = reg_addr == csd_pkg::CSD_STAT_OFS;
    // Static settings are frozen while the core runs; only dynamic bits accept writes then
    assign static_lock = core_running;

    always_comb begin
        ctrl_next = ctrl_reg;
        if (reg_wr && sel_ctrl) begin
            // Dynamic bits: always writable
            ctrl_next.data_bus_drive_en = reg_wdata[csd_pkg::CSD_CTRL_DATA_EN_BIT];
            ctrl_next.write_drive_en_n = reg_wdata[csd_pkg::CSD_CTRL_WDE_BIT];
            ctrl_next.debug_entry_request = reg_wdata[csd_pkg::CSD_CTRL_DEBUG_REQ_BIT];
            ctrl_next.ext_watch_cond0 = reg_wdata[csd_pkg::CSD_CTRL_EXT0_BIT];
            ctrl_next.ext_watch_cond1 = reg_wdata[csd_pkg::CSD_CTRL_EXT1_BIT];
            if (!static_lock) begin
                ctrl_next.debug_feature_en = reg_wdata[csd_pkg::CSD_CTRL_DEBUG_EN_BIT];
                ctrl_next.irq_sync_select = reg_wdata[csd_pkg::CSD_CTRL_IRQ_SYNC_BIT];
                ctrl_next.test_float_en = reg_wdata[csd_pkg::CSD_CTRL_FLOAT_EN_BIT];
            end
        end
    end

    always_comb begin
        test_next = test_reg;
        if (reg_wr && sel_test) begin
            test_next.test_port_reset_n = reg_wdata[csd_pkg::CSD_TEST_PORT_RST_BIT];
            test_next.test_clock = reg_wdata[csd_pkg::CSD_TEST_TCK_BIT];
            test_next.test_data_in = reg_wdata[csd_pkg::CSD_TEST_TDI_BIT];
            test_next.test_mode_select = reg_wdata[csd_pkg::CSD_TEST_TMS_BIT];
        end
        // Scan return follows the chain only when one is attached, otherwise tied low
        test_next.ext_scan_return = chain_s & scan_s;
    end

    // ------------------------------------------------------------
    // Coprocessor handshake
    // ------------------------------------------------------------
    csd_pkg::csd_cp_state_t cp_reg;
    csd_pkg::csd_cp_state_t cp_next;
    logic [1:0] cp_cnt_reg;
    logic [1:0] cp_cnt_next;
    logic can_serve;
    logic absent_next;
    logic wait_next;

    assign can_serve = cp_attached_s & cp_capable_s;

    always_comb begin
        cp_next = cp_reg;
        cp_cnt_next = cp_cnt_reg;
        unique case (cp_reg)
            csd_pkg::CSD_CP_IDLE: begin
                if (!strobe_n_s && can_serve) begin
                    cp_next = csd_pkg::CSD_CP_WAIT;
                    cp_cnt_next = 2'(csd_pkg::CSD_CP_READY_CYC - 1);
                end
            end
            csd_pkg::CSD_CP_WAIT: begin
                if (strobe_n_s || !can_serve) begin
                    cp_next = csd_pkg::CSD_CP_IDLE;
                end else if (cp_cnt_reg == 2'h0) begin
                    cp_next = csd_pkg::CSD_CP_GO;
                end else begin
                    cp_cnt_next = cp_cnt_reg - 2'h1;
                end
            end
            csd_pkg::CSD_CP_GO: begin
                if (strobe_n_s || !can_serve) begin
                    cp_next = csd_pkg::CSD_CP_IDLE;
                end
            end
            default: cp_next = csd_pkg::CSD_CP_IDLE;
        endcase
    end

    // Absent low only while a capable coprocessor is attached and asked
    assign absent_next = !(can_serve && !strobe_n_s);
    // Wait stays high until the coprocessor reaches its ready state; the core
    // samples it every cycle the strobe is low, so it must be valid then
    assign wait_next = cp_next != csd_pkg::CSD_CP_GO;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrl_reg <= csd_pkg::csd_ctrl_t'(csd_pkg::CSD_CTRL_RST);
            test_reg <= csd_pkg::csd_test_t'(csd_pkg::CSD_TEST_RST);
            cp_reg <= csd_pkg::CSD_CP_IDLE;
            cp_cnt_reg <= 2'h0;
            coproc_absent <= 1'b1;
            coproc_wait <= 1'b1;
            reg_rdata <= 32'h0;
        end else begin
            ctrl_reg <= ctrl_next;
            test_reg <= test_next;
            cp_reg <= cp_next;
            cp_cnt_reg <= cp_cnt_next;
            coproc_absent <= absent_next;
            coproc_wait <= wait_next;
            reg_rdata <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------
    logic [31:0] rd_ctrl;
    logic [31:0] rd_test;
    logic [31:0] rd_stat;

    assign rd_ctrl = {24'h0, ctrl_reg.test_float_en, ctrl_reg.irq_sync_select, ctrl_reg.ext_watch_cond1,
                      ctrl_reg.ext_watch_cond0, ctrl_reg.debug_entry_request, ctrl_reg.debug_feature_en,
                      ctrl_reg.write_drive_en_n, ctrl_reg.data_bus_drive_en};
    assign rd_test = {27'h0, test_reg.ext_scan_return, test_reg.test_mode_select, test_reg.test_data_in,
                      test_reg.test_clock, test_reg.test_port_reset_n};
    assign rd_stat = {25'h0, static_lock, coproc_wait, coproc_absent, cp_reg, chain_s};
    // Unmapped addresses read zero
    assign rdata_next = !reg_rd ? 32'h0 :
                        sel_ctrl ? rd_ctrl :
                        sel_test ? rd_test :
                        sel_stat ? rd_stat : 32'h0;

    // ------------------------------------------------------------
    // Outputs (all registered)
    // ------------------------------------------------------------
    assign data_bus_drive_en = ctrl_reg.data_bus_drive_en;
    assign write_drive_en_n = ctrl_reg.write_drive_en_n;
    assign debug_feature_en = ctrl_reg.debug_feature_en;
    assign debug_entry_request = ctrl_reg.debug_entry_request;
    assign ext_watch_cond0 = ctrl_reg.ext_watch_cond0;
    assign ext_watch_cond1 = ctrl_reg.ext_watch_cond1;
    assign irq_sync_select = ctrl_reg.irq_sync_select;
    assign test_float_en = ctrl_reg.test_float_en;
    assign test_port_reset_n = test_reg.test_port_reset_n;
    assign test_clock = test_reg.test_clock;
    assign test_data_in = test_reg.test_data_in;
    assign test_mode_select = test_reg.test_mode_select;
    assign ext_scan_return = test_reg.ext_scan_return;
endmodule

// file: rtl/csd_pkg.sv
// Package for the core sideband control drive block.
// Assumes a single clock mclk and a synchronous active-high reset.
package csd_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] CSD_CTRL_OFS = 4'h0;
    localparam logic [3:0] CSD_TEST_OFS = 4'h4;
    localparam logic [3:0] CSD_STAT_OFS = 4'h8;

    // Control register bit positions
    localparam int CSD_CTRL_DATA_EN_BIT = 0;
    localparam int CSD_CTRL_WDE_BIT = 1;
    localparam int CSD_CTRL_DEBUG_EN_BIT = 2;
    localparam int CSD_CTRL_DEBUG_REQ_BIT = 3;
    localparam int CSD_CTRL_EXT0_BIT = 4;
    localparam int CSD_CTRL_EXT1_BIT = 5;
    localparam int CSD_CTRL_IRQ_SYNC_BIT = 6;
    localparam int CSD_CTRL_FLOAT_EN_BIT = 7;

    // Test register bit positions
    localparam int CSD_TEST_PORT_RST_BIT = 0;
    localparam int CSD_TEST_TCK_BIT = 1;
    localparam int CSD_TEST_TDI_BIT = 2;
    localparam int CSD_TEST_TMS_BIT = 3;
    localparam int CSD_TEST_SCAN_BIT = 4;

    // Reset values: buses enabled, debug on, synchronous interrupts, test port held in reset
    localparam logic [7:0] CSD_CTRL_RST = 8'hc5;
    localparam logic [4:0] CSD_TEST_RST = 5'h00;

    // Coprocessor handshake after a strobe: the attached unit is ready this many cycles later
    localparam int CSD_CP_READY_CYC = 2;

    // Members run from the top bit down, so a cast of a register word lands each bit on its field
    typedef struct packed {
        logic test_float_en;
        logic irq_sync_select;
        logic ext_watch_cond1;
        logic ext_watch_cond0;
        logic debug_entry_request;
        logic debug_feature_en;
        logic write_drive_en_n;
        logic data_bus_drive_en;
    } csd_ctrl_t;

    typedef struct packed {
        logic ext_scan_return;
        logic test_mode_select;
        logic test_data_in;
        logic test_clock;
        logic test_port_reset_n;
    } csd_test_t;

    typedef enum logic [2:0] {
        CSD_CP_IDLE = 3'b001,
        CSD_CP_WAIT = 3'b010,
        CSD_CP_GO = 3'b100
    } csd_cp_state_t;

endpackage

// file: rtl/csd_sync.sv
// Three-stage pin synchroniser; output changes when stages two and three agree.
// Assumes the input is asynchronous to mclk.
`timescale 1ns/1ps
module csd_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] out_next;

    // Per bit: take the new value only once two stages agree
    assign out_next = (s2_reg & s3_reg) | (sync_out & (s2_reg | s3_reg));

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s1_reg <= INIT;
            s2_reg <= INIT;
            s3_reg <= INIT;
            sync_out <= INIT;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            sync_out <= out_next;
        end
    end
endmodule

// file: testbench/csd_top_sva.sv
// Port assertions for the sideband drive block.
// Assumes one clock mclk and the synchronous active-high reset sys_rst.
`timescale 1ns/1ps
module csd_top_sva (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic coproc_attached,
    input wire logic coproc_capable,
    input wire logic ext_chain_attached,
    input wire logic core_running,
    input wire logic coproc_absent,
    input wire logic coproc_wait,
    input wire logic data_bus_drive_en,
    input wire logic write_drive_en_n,
    input wire logic debug_feature_en,
    input wire logic debug_entry_request,
    input wire logic ext_watch_cond0,
    input wire logic ext_watch_cond1,
    input wire logic irq_sync_select,
    input wire logic test_float_en,
    input wire logic test_port_reset_n,
    input wire logic test_clock,
    input wire logic test_data_in,
    input wire logic test_mode_select,
    input wire logic ext_scan_return
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // ------------------------------------------------------------
    // Coprocessor handshake
    // ------------------------------------------------------------
    sequence s_granted;
        $fell(coproc_absent) ##1 !coproc_absent [*2];
    endsequence
    chk_absent_cause: assert property (
        $fell(coproc_absent) |-> $past(coproc_attached, 2) && $past(coproc_capable, 2))
        else $error("absent fell with no capable coprocessor");
    chk_absent_idle: assert property (
        !coproc_attached [*7] |-> coproc_absent && coproc_wait)
        else $error("handshake active with no coprocessor");
    chk_wait_hold: assert property (
        $fell(coproc_absent) |-> coproc_wait ##1 coproc_wait)
        else $error("ready given too early");
    chk_wait_ready: assert property (s_granted |-> !coproc_wait)
        else $error("ready not given two cycles after absent fell");
    chk_wait_absent: assert property (!coproc_wait |-> !coproc_absent)
        else $error("ready given while absent high");
    // ------------------------------------------------------------
    // Register driven levels
    // ------------------------------------------------------------
    chk_static_lock: assert property (
        core_running && $past(core_running) && !$past(sys_rst)
        |-> $stable({test_float_en, irq_sync_select, debug_feature_en}))
        else $error("static level changed while core running");
    chk_ctrl_write: assert property (
        reg_wr && reg_addr == csd_pkg::CSD_CTRL_OFS |=>
        {ext_watch_cond1, ext_watch_cond0, debug_entry_request, write_drive_en_n, data_bus_drive_en}
        == {$past(reg_wdata[5:3]), $past(reg_wdata[1:0])}
        && ($past(core_running) || {test_float_en, irq_sync_select, debug_feature_en}
        == {$past(reg_wdata[7:6]), $past(reg_wdata[2])}))
        else $error("control write not reflected on pins");
    chk_test_write: assert property (
        reg_wr && reg_addr == csd_pkg::CSD_TEST_OFS |=>
        {test_mode_select, test_data_in, test_clock, test_port_reset_n} == $past(reg_wdata[3:0]))
        else $error("test write not reflected on pins");
    chk_scan_gated: assert property (!ext_chain_attached [*7] |-> !ext_scan_return)
        else $error("scan return not low without chain");
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read cycle");
endmodule

bind csd_top csd_top_sva u_sva (.*);

// file: testbench/csd_core_model.sv
// Processor core stand-in: drives the coprocessor strobe, watches drive levels.
// Assumes the bench sets cp_req on mclk edges; the strobe idles high.
`timescale 1ns/1ps
module csd_core_model (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic cp_req,
    input wire logic coproc_wait,
    input wire logic data_bus_drive_en,
    input wire logic write_drive_en_n,
    input wire logic test_float_en,
    output logic coproc_instr_strobe_n,
    output logic drives_data,
    output logic [7:0] stall_count
);
    // Write data leaves the core only when every enable allows it
    assign drives_data = data_bus_drive_en && !write_drive_en_n && test_float_en;
    always_ff @(posedge mclk) begin
        coproc_instr_strobe_n <= sys_rst || !cp_req;
    end
    // Busy is looked at on every rising edge that sees the strobe low
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            stall_count <= 8'h00;
        end else if (!coproc_instr_strobe_n && coproc_wait) begin
            stall_count <= stall_count + 8'h01;
        end
    end
endmodule

// file: testbench/csd_top_test.sv
// Self-checking bench for the sideband drive block.
// Assumes the core model drives the strobe; everything else comes from here.
`timescale 1ns/1ps
module csd_top_test;
    localparam logic [3:0] A_CTRL = csd_pkg::CSD_CTRL_OFS;
    localparam logic [3:0] A_TEST = csd_pkg::CSD_TEST_OFS;
    localparam logic [3:0] A_STAT = csd_pkg::CSD_STAT_OFS;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic cp_req = 1'b0;
    logic coproc_attached = 1'b0;
    logic coproc_capable = 1'b0;
    logic ext_chain_attached = 1'b0;
    logic ext_scan_data = 1'b1;
    logic core_running = 1'b0;
    logic [31:0] reg_rdata;
    logic [7:0] stall_count;
    logic coproc_instr_strobe_n, coproc_absent, coproc_wait, drives_data, ext_scan_return;
    logic data_bus_drive_en, write_drive_en_n, debug_feature_en, debug_entry_request;
    logic ext_watch_cond0, ext_watch_cond1, irq_sync_select, test_float_en;
    logic test_port_reset_n, test_clock, test_data_in, test_mode_select;
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;
    wire logic [7:0] ctrl_pins = {test_float_en, irq_sync_select, ext_watch_cond1, ext_watch_cond0,
        debug_entry_request, debug_feature_en, write_drive_en_n, data_bus_drive_en};
    wire logic [3:0] test_pins = {test_mode_select, test_data_in, test_clock, test_port_reset_n};
    wire logic [1:0] hs = {coproc_absent, coproc_wait};

    csd_top u_dut (.*);
    csd_core_model u_core (.*);

    initial begin
        forever #12.5 mclk = ~mclk;
    end
    // Cuts a hang short; the full sequence needs about 80 cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_check(input logic [3:0] a, input logic [31:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask
    // Pins pass a four-flop synchroniser, so each step settles for ten cycles
    task automatic settle;
        repeat (10) @(posedge mclk);
        #1;
    endtask
    task automatic tally_and_finish;
        if (mismatches == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        rd_check(A_CTRL, 32'hc5);
        rd_check(A_TEST, 32'h00);
        rd_check(4'hc, 32'h00);
        check(32'(ctrl_pins), 32'hc5);
        wr(A_CTRL, 32'h5a);
        rd_check(A_CTRL, 32'h5a);
        check(32'(ctrl_pins), 32'h5a);
        @(posedge mclk) core_running <= 1'b1;
        wr(A_CTRL, 32'ha5);
        rd_check(A_CTRL, 32'h61);
        check(32'(drives_data), 32'h0);
        wr(A_TEST, 32'h1f);
        rd_check(A_TEST, 32'h0f);
        check(32'(test_pins), 32'hf);
        @(posedge mclk) ext_chain_attached <= 1'b1;
        settle();
        check(32'(ext_scan_return), 32'h1);
        rd_check(A_STAT, 32'h73);
        @(posedge mclk) ext_chain_attached <= 1'b0;
        settle();
        check(32'(ext_scan_return), 32'h0);
        @(posedge mclk) coproc_attached <= 1'b1;
        cp_req <= 1'b1;
        settle();
        check(32'(hs), 32'h3);
        @(posedge mclk) coproc_capable <= 1'b1;
        settle();
        check(32'(hs), 32'h0);
        check(32'(stall_count != 8'h00), 32'h1);
        rd_check(A_STAT, 32'h48);
        @(posedge mclk) cp_req <= 1'b0;
        settle();
        check(32'(hs), 32'h3);
        tally_and_finish();
    end
endmodule
